// File: bench/dsfr_serial_frame_tb_top.sv
`timescale 1ns/100ps
module dsfr_serial_frame_tb_top;
  localparam int LIMIT = 60000;
  logic        mclk       = 1'h0;
  logic        resetn     = 1'h0;
  logic        hw_addr_hi = 1'h0;
  logic        hw_addr_lo = 1'h0;
  logic        fault_pin  = 1'h0;
  logic        crc_enable = 1'h1;
  logic [11:0] adc_result = 12'h000;
  logic        sclk, sync_n, sdi, sdo, sdo_oe;
  logic        adc_start, frame_valid, frame_error, invalid_access;
  logic [4:0]  diag_input_sel;
  logic [31:0] rs = 32'h56;
  logic [31:0] got;
  logic        oe;
  logic [1:0]  me;
  int          lens[4] = '{24, 31, 32, 33};
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n_v = 0;
  int          n_e = 0;
  int          n_i = 0;
  int          n_s = 0;
  int          dv, de, di, ds;

  always #4 mclk = ~mclk;

  dsfr_serial_frame dsfr_serial_frame_inst (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .hw_addr_hi(hw_addr_hi), .hw_addr_lo(hw_addr_lo), .fault_pin(fault_pin), .crc_enable(crc_enable),
    .adc_result(adc_result), .adc_start(adc_start), .diag_input_sel(diag_input_sel),
    .frame_valid(frame_valid), .frame_error(frame_error), .invalid_access(invalid_access)
  );

  dsfr_spi_host dsfr_spi_host_inst (
    .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  // Pulses last one cycle, so they are tallied here rather than polled
  always @(posedge mclk) begin
    n_v <= n_v + int'(frame_valid === 1'h1);
    n_e <= n_e + int'(frame_error === 1'h1);
    n_i <= n_i + int'(invalid_access === 1'h1);
    n_s <= n_s + int'(adc_start === 1'h1);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  function automatic logic [31:0] nxt();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : nxt

  function automatic logic [23:0] cw(input logic [1:0] dev, input logic [4:0] adr, input logic [15:0] d);
    return {~dev[1], dev, adr, d};
  endfunction : cw

  function automatic logic [15:0] cfg(input logic [2:0] c, input logic [2:0] a, input logic [4:0] s);
    return {5'h00, c, a, s};
  endfunction : cfg

  function automatic logic [31:0] stat(input logic busy, input logic [4:0] sel, input logic [11:0] res);
    return {1'h0, busy, fault_pin, sel, 4'h0, res, 8'h00};
  endfunction : stat

  function automatic logic [31:0] rdw(input logic [4:0] adr, input logic [15:0] d);
    return {dsfr_pkg::SYNC_PAT, fault_pin, adr, d, 8'h00};
  endfunction : rdw

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Frame plus a settle margin wide enough for the synchronised pulses
  task automatic run(input int len, input logic [23:0] c);
    int v0, e0, i0, s0;
    v0 = n_v;
    e0 = n_e;
    i0 = n_i;
    s0 = n_s;
    dsfr_spi_host_inst.xfer(len, {c, dsfr_pkg::CRC_FILL, 8'h00}, got, oe);
    repeat (8) @(posedge mclk);
    dv = n_v - v0;
    de = n_e - e0;
    di = n_i - i0;
    ds = n_s - s0;
  endtask : run

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial begin
    logic [31:0] r;
    logic [4:0]  sa, sb;
    logic [11:0] r1;
    logic [23:0] w;
    int          ok;
    r = nxt();
    me = r[1:0];
    sa = r[6:2];
    sb = r[11:7];
    r1 = r[23:12];
    @(posedge mclk);
    hw_addr_hi <= me[1];
    hw_addr_lo <= me[0];
    fault_pin <= r[24];
    adc_result <= r1;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    repeat (4) @(posedge mclk);
    check({31'h0, sdo_oe}, 32'h0);
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(got, rdw(dsfr_pkg::ADR_NOP, 16'h0000));
    for (int c = 1; c >= 0; c--) begin
      @(posedge mclk);
      crc_enable <= c[0];
      foreach (lens[j]) begin
        run(lens[j], cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
        ok = c ? int'(lens[j] == 32) : int'(lens[j] == 24 || lens[j] == 32);
        check(dv, ok);
        check(de, 1 - ok);
      end
    end
    @(posedge mclk);
    crc_enable <= 1'h1;
    run(32, {me[1], me, dsfr_pkg::ADR_NOP, 16'h0000});
    check(de, 1);
    check(dv, 0);
    for (int d = 0; d < 4; d++) begin
      run(32, cw(d[1:0], dsfr_pkg::ADR_NOP, 16'h0000));
      check(dv, int'(d[1:0] == me));
      check(de, 0);
    end
    for (int a = 'h14; a < 'h20; a++) begin
      run(32, cw(me, a[4:0], 16'h0000));
      check(di, int'((a >= 'h19 && a <= 'h1b) || a > 'h1c));
      check(dv, 1);
    end
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h001a));
    check(di, 1);
    check(dv, 1);
    w = {8'h00, cfg(dsfr_pkg::SQ_DEPTH, 3'h1, sb)};
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, w[15:0]));
    check(got, rdw(5'h1a, 16'h0000));
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h0011));
    check(di, 0);
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h0013));
    check(got, rdw(dsfr_pkg::ADR_ADC_CFG, w[15:0]));
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(got, rdw(dsfr_pkg::ADR_RB_SEL, 16'h0013));
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h0100));
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_SINGLE, 3'h0, sa)));
    check(got, stat(1'h0, 5'h00, 12'h000));
    check(ds, 1);
    check(diag_input_sel, sa);
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(got, stat(1'h1, 5'h00, 12'h000));
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(got, stat(1'h0, sa, r1));
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_LOAD, 3'h0, sa)));
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_LOAD, 3'h1, sb)));
    check(ds, 0);
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_KEY, 3'h1, 5'h00)));
    check(ds, 1);
    check(diag_input_sel, sa);
    for (int k = 0; k < 3; k++) begin
      run(32, cw(me, dsfr_pkg::ADR_KEY, dsfr_pkg::KEY_CONVERT));
      check(ds, 1);
      check(diag_input_sel, k[0] ? sa : sb);
    end
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h0300));
    r = nxt();
    w = cw(me, 5'h14, r[15:0]);
    run(32, w);
    check(got, stat(1'h0, sb, r1));
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(got, {w, 8'h00});
    run(32, cw(me, dsfr_pkg::ADR_RB_SEL, 16'h0200));
    run(32, cw(~me, dsfr_pkg::ADR_NOP, 16'h0000));
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(oe, 1'h0);
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(oe, 1'h1);
    check(got, stat(1'h0, sb, r1));
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_AUTO, 3'h1, 5'h00)));
    check(ds, 1);
    check(diag_input_sel, sa);
    run(32, cw(me, dsfr_pkg::ADR_NOP, 16'h0000));
    check(ds, 1);
    check(diag_input_sel, sb);
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_AUTO, 3'h0, 5'h00)));
    check(ds, 0);
    run(32, cw(me, dsfr_pkg::ADR_ADC_CFG, cfg(dsfr_pkg::SQ_SKEY, 3'h0, sa)));
    check(ds, 0);
    run(32, cw(me, dsfr_pkg::ADR_KEY, dsfr_pkg::KEY_CONVERT));
    check(ds, 1);
    check(diag_input_sel, sa);
    wrap_up();
  end
endmodule : dsfr_serial_frame_tb_top

// File: bench/dsfr_spi_host.sv
`timescale 1ns/100ps
module dsfr_spi_host (
  // Serial pins toward the device
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi,
  // Device output and its enable
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic last_sdo = 1'h0;
  logic line;

  // No pull on the output wire: once released it shows the inverse of its last value
  always @(sdo or sdo_oe) begin
    if (sdo_oe) last_sdo = sdo;
  end
  assign line = sdo_oe ? sdo : ~last_sdo;

  initial begin
    sclk = 1'h0;
    sync_n = 1'h1;
    sdi = 1'h0;
  end

  // One frame, MSB first; the serial clock stands still outside frames
  task automatic xfer(input int len, input logic [39:0] bits, output logic [31:0] got, output logic oe_seen);
    // Off the mclk edge grid, so no pin change meets a sampling edge
    #0.3;
    got = '0;
    oe_seen = 1'h0;
    sync_n = 1'h0;
    for (int i = 0; i < len; i++) begin
      sdi = bits[39-i];
      #62.5;
      sclk = 1'h1;
      got = {got[30:0], line};
      oe_seen = oe_seen | (sdo_oe === 1'h1);
      #62.5;
      sclk = 1'h0;
    end
    #62.5;
    sync_n = 1'h1;
    sdi = ~sdi;
    #100;
  endtask : xfer
endmodule : dsfr_spi_host

// File: rtl/dsfr_pkg.sv
package dsfr_pkg;
  // Timing
  localparam int CLK_NS   = 8;
  localparam int CONV_NS  = 1000;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  // Frame lengths
  localparam logic [5:0] LEN_CRC   = 6'h20;
  localparam logic [5:0] LEN_PLAIN = 6'h18;
  // Register addresses
  localparam logic [4:0] ADR_NOP     = 5'h00;
  localparam logic [4:0] ADR_KEY     = 5'h08;
  localparam logic [4:0] ADR_ADC_CFG = 5'h11;
  localparam logic [4:0] ADR_RB_SEL  = 5'h13;
  localparam logic [4:0] ADR_STATUS  = 5'h16;
  localparam logic [4:0] ADR_RSV_LO  = 5'h19;
  localparam logic [4:0] ADR_RSV_HI  = 5'h1b;
  localparam logic [4:0] ADR_LAST    = 5'h1c;
  // Values
  localparam logic [15:0] KEY_CONVERT = 16'h1adc;
  localparam logic [1:0]  SYNC_PAT    = 2'h2;
  localparam logic [15:0] RB_SEL_RST  = 16'h0000;
  localparam logic [15:0] ADC_CFG_RST = 16'h0000;
  localparam logic [7:0]  CRC_FILL    = 8'h00;
  // Field positions
  localparam int RB_MODE_LSB = 8;
  localparam int RB_ADR_LSB  = 0;
  localparam int STAT_BUSY   = 30;

  typedef enum logic [1:0] {
    RB_TWO_STAGE = 2'h0,
    RB_AUTO      = 2'h1,
    RB_SHARED    = 2'h2,
    RB_ECHO      = 2'h3
  } dsfr_rb_mode_t;

  typedef enum logic [2:0] {
    SQ_DEPTH  = 3'h0,
    SQ_LOAD   = 3'h1,
    SQ_KEY    = 3'h2,
    SQ_AUTO   = 3'h3,
    SQ_SINGLE = 3'h4,
    SQ_SKEY   = 3'h5
  } dsfr_sq_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } dsfr_state_t;

  typedef struct packed {
    logic        slip;
    logic [1:0]  dev;
    logic [4:0]  adr;
    logic [15:0] data;
  } dsfr_cmd_t;

  typedef struct packed {
    logic [4:0]  pad;
    logic [2:0]  cmd;
    logic [2:0]  arg;
    logic [4:0]  sel;
  } dsfr_adc_cfg_t;
endpackage : dsfr_pkg

// File: rtl/dsfr_serial_frame.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Status keeps the latest finished conversion result and its input selection.
// - An autostatus frame during a conversion returns the older result with busy set.
// - Conversion commands arriving while busy are dropped.
// - The sequencer pointer advances only after the running conversion ends.
// - Access to a reserved register address is flagged invalid.
// - With checking on, only exactly 32-bit frames are accepted.
// - With checking off, 24-bit and 32-bit frames are accepted, tail ignored.
// - Frame bits 22 and 21 must match the two address pins.
// - Bits 20 to 16 select the register, bits 15 to 0 carry data.
// - Four readback behaviours chosen by the mode field of readback_select.
// - Two-stage: select register at 0x13, next frame shifts its contents out.
// - A new two-stage request may ride in the collecting frame.
// - Read frame opens with 10, then fault bit, address, sixteen data bits.
// - Autostatus returns the status word during every frame.
// - Shared-select: flag set on valid write, cleared at next select fall.
// - Echo: like autostatus, every second frame returns the previous command.
// - Converter config: command bits 10:8, data 7:5, input selection 4:0.
// - Command 010 enables key sequencing; each key write steps the channel.
// - No-operation is zero data at address zero; reads back zero.
module dsfr_serial_frame #(
  parameter int RES_W    = 12,
  parameter int SEQ_N    = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Serial pins
  input  wire logic             sclk,
  input  wire logic             sync_n,
  input  wire logic             sdi,
  output logic                  sdo,
  output logic                  sdo_oe,
  // Straps and status pins
  input  wire logic             hw_addr_hi,
  input  wire logic             hw_addr_lo,
  input  wire logic             fault_pin,
  // Configuration
  input  wire logic             crc_enable,
  // Diagnostic converter
  input  wire logic [RES_W-1:0] adc_result,
  output logic                  adc_start,
  output logic [4:0]            diag_input_sel,
  // Frame events
  output logic                  frame_valid,
  output logic                  frame_error,
  output logic                  invalid_access
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin synchronisers: {fault, addr_hi, addr_lo, sdi, sync_n, sclk}
  logic [5:0] meta, sy, sy_d;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta <= 6'h02;
      sy   <= 6'h02;
      sy_d <= 6'h02;
    end else begin
      meta <= {fault_pin, hw_addr_hi, hw_addr_lo, sdi, sync_n, sclk};
      sy   <= meta;
      sy_d <= sy;
    end
  end
  logic sclk_rise, sclk_fall, frm_start, frm_end;
  assign sclk_rise = sy[0] & ~sy_d[0];
  assign sclk_fall = ~sy[0] & sy_d[0];
  assign frm_start = ~sy[1] & sy_d[1];
  assign frm_end   = sy[1] & ~sy_d[1];

  // Frame state
  dsfr_pkg::dsfr_state_t state;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= dsfr_pkg::ST_IDLE;
    end else begin
      case (state)
        dsfr_pkg::ST_IDLE:  if (frm_start) state <= dsfr_pkg::ST_FRAME;
        dsfr_pkg::ST_FRAME: if (frm_end) state <= dsfr_pkg::ST_IDLE;
        default:            state <= dsfr_pkg::ST_IDLE;
      endcase
    end
  end

  // Input shifter; count saturates so overlong frames stay rejected
  logic [31:0] sh;
  logic [5:0]  cnt;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sh  <= 32'h0;
      cnt <= 6'h0;
    end else if (frm_start) begin
      cnt <= 6'h0;
    end else if (state == dsfr_pkg::ST_FRAME && sclk_rise) begin
      sh  <= {sh[30:0], sy[2]};
      cnt <= (cnt == 6'h3f) ? cnt : cnt + 6'h1;
    end
  end

  // Frame decode
  dsfr_pkg::dsfr_cmd_t cmd;
  logic len_ok, slip_ok, dev_ok, rsv, rb_rsv, frame_ok, wr_ok;
  assign cmd      = (cnt == dsfr_pkg::LEN_CRC) ? sh[31:8] : sh[23:0];
  assign len_ok   = crc_enable ? (cnt == dsfr_pkg::LEN_CRC)
                  : (cnt == dsfr_pkg::LEN_PLAIN || cnt == dsfr_pkg::LEN_CRC);
  assign slip_ok  = cmd.slip != cmd.dev[1];
  assign dev_ok   = cmd.dev == sy[4:3];
  assign rsv      = (cmd.adr >= dsfr_pkg::ADR_RSV_LO && cmd.adr <= dsfr_pkg::ADR_RSV_HI)
                  || cmd.adr > dsfr_pkg::ADR_LAST;
  assign rb_rsv   = cmd.adr == dsfr_pkg::ADR_RB_SEL && ((cmd.data[4:0] >= dsfr_pkg::ADR_RSV_LO
                  && cmd.data[4:0] <= dsfr_pkg::ADR_RSV_HI) || cmd.data[4:0] > dsfr_pkg::ADR_LAST);
  assign frame_ok = frm_end && state == dsfr_pkg::ST_FRAME && len_ok && slip_ok && dev_ok;
  assign wr_ok    = frame_ok & ~rsv;
  dsfr_pkg::dsfr_cmd_t last_cmd;
  logic [15:0] readback_select, adc_config;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frame_valid    <= 1'b0;
      frame_error    <= 1'b0;
      invalid_access <= 1'b0;
      last_cmd       <= '0;
    end else begin
      frame_valid    <= frame_ok;
      frame_error    <= frm_end && state == dsfr_pkg::ST_FRAME && !(len_ok && slip_ok);
      invalid_access <= frame_ok & (rsv | rb_rsv);
      if (frame_ok) last_cmd <= cmd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      readback_select <= dsfr_pkg::RB_SEL_RST;
      adc_config      <= dsfr_pkg::ADC_CFG_RST;
    end else if (wr_ok && cmd.adr == dsfr_pkg::ADR_RB_SEL) begin
      readback_select <= cmd.data;
    end else if (wr_ok && cmd.adr == dsfr_pkg::ADR_ADC_CFG) begin
      adc_config      <= cmd.data;
    end
  end

  // Converter and sequencer
  dsfr_pkg::dsfr_adc_cfg_t cfg;
  logic             busy, conv_done, seq_conv, key_seq, auto_seq, skey_armed;
  logic             cfg_cmd, key_hit, start_req, start_seq;
  logic [15:0]      conv_cnt;
  logic [RES_W-1:0] res;
  logic [4:0]       res_sel, skey_sel, start_sel;
  logic [2:0]       depth, ptr;
  logic [4:0]       chan [SEQ_N];
  assign cfg       = cmd.data;
  assign conv_done = busy && conv_cnt == 16'h0;
  assign cfg_cmd   = wr_ok && cmd.adr == dsfr_pkg::ADR_ADC_CFG && !busy;
  assign key_hit   = wr_ok && cmd.adr == dsfr_pkg::ADR_KEY && cmd.data == dsfr_pkg::KEY_CONVERT && !busy;

  always_comb begin
    start_req = 1'b0;
    start_seq = 1'b0;
    start_sel = chan[ptr];
    if (cfg_cmd) begin
      case (cfg.cmd)
        dsfr_pkg::SQ_KEY, dsfr_pkg::SQ_AUTO: begin
          start_req = cfg.arg[0];
          start_seq = 1'b1;
          start_sel = chan[0];
        end
        dsfr_pkg::SQ_SINGLE: begin
          start_req = 1'b1;
          start_sel = cfg.sel;
        end
        default: start_req = 1'b0;
      endcase
    end else if (key_hit) begin
      start_req = key_seq | skey_armed;
      start_seq = key_seq;
      start_sel = key_seq ? chan[ptr] : skey_sel;
    end else if (auto_seq && wr_ok && !busy) begin
      start_req = 1'b1;
      start_seq = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      depth      <= 3'h0;
      ptr        <= 3'h0;
      key_seq    <= 1'b0;
      auto_seq   <= 1'b0;
      skey_armed <= 1'b0;
      skey_sel   <= 5'h0;
      chan       <= '{default: 5'h0};
    end else if (cfg_cmd) begin
      case (cfg.cmd)
        dsfr_pkg::SQ_DEPTH: depth <= cfg.arg;
        dsfr_pkg::SQ_LOAD:  chan[cfg.arg] <= cfg.sel;
        dsfr_pkg::SQ_KEY: begin
          key_seq  <= cfg.arg[0];
          auto_seq <= 1'b0;
          ptr      <= 3'h0;
        end
        dsfr_pkg::SQ_AUTO: begin
          auto_seq <= cfg.arg[0];
          key_seq  <= 1'b0;
          ptr      <= 3'h0;
        end
        dsfr_pkg::SQ_SINGLE: auto_seq <= 1'b0;
        dsfr_pkg::SQ_SKEY: begin
          skey_sel   <= cfg.sel;
          skey_armed <= 1'b1;
        end
        default: skey_armed <= skey_armed;
      endcase
    end else if (conv_done && seq_conv) begin
      // Busy blocks config commands, so this never meets a pointer reset
      ptr <= (ptr == depth) ? 3'h0 : ptr + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy           <= 1'b0;
      conv_cnt       <= 16'h0;
      seq_conv       <= 1'b0;
      diag_input_sel <= 5'h0;
      adc_start      <= 1'b0;
      res            <= '0;
      res_sel        <= 5'h0;
    end else begin
      adc_start <= start_req;
      if (start_req) begin
        busy           <= 1'b1;
        conv_cnt       <= 16'(dsfr_pkg::CONV_CYC - 1);
        seq_conv       <= start_seq;
        diag_input_sel <= start_sel;
      end else if (conv_done) begin
        busy    <= 1'b0;
        res     <= adc_result;
        res_sel <= diag_input_sel;
      end else if (busy) begin
        conv_cnt <= conv_cnt - 16'h1;
      end
    end
  end

  // Readback
  dsfr_pkg::dsfr_rb_mode_t mode;
  logic [15:0] status16, rd_data;
  logic [23:0] status24, out_w;
  logic [4:0]  rb_adr;
  logic        drive, shared_flag, echo_ph;
  logic [31:0] txs;
  assign mode     = dsfr_pkg::dsfr_rb_mode_t'(readback_select[dsfr_pkg::RB_MODE_LSB +: 2]);
  assign rb_adr   = readback_select[dsfr_pkg::RB_ADR_LSB +: 5];
  assign status16 = 16'(res);
  assign status24 = {1'b0, busy, sy[5], res_sel, status16};

  always_comb begin
    if (rb_adr == dsfr_pkg::ADR_RB_SEL) begin
      rd_data = readback_select;
    end else if (rb_adr == dsfr_pkg::ADR_ADC_CFG) begin
      rd_data = adc_config;
    end else if (rb_adr == dsfr_pkg::ADR_STATUS) begin
      rd_data = status16;
    end else begin
      rd_data = 16'h0;
    end
  end

  always_comb begin
    out_w = status24;
    drive = 1'b1;
    case (mode)
      dsfr_pkg::RB_TWO_STAGE: out_w = {dsfr_pkg::SYNC_PAT, sy[5], rb_adr, rd_data};
      dsfr_pkg::RB_SHARED:    drive = shared_flag;
      dsfr_pkg::RB_ECHO:      out_w = echo_ph ? last_cmd : status24;
      default:                drive = 1'b1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      shared_flag <= 1'b0;
    end else if (wr_ok) begin
      shared_flag <= 1'b1;
    end else if (frm_start) begin
      shared_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      echo_ph <= 1'b0;
    end else if (frm_start && mode == dsfr_pkg::RB_ECHO) begin
      echo_ph <= ~echo_ph;
    end
  end

  // Check byte is not generated; its slot shifts out as fill
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      txs    <= 32'h0;
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (frm_start) begin
      txs    <= {out_w, dsfr_pkg::CRC_FILL};
      sdo    <= out_w[23];
      sdo_oe <= drive;
    end else if (frm_end) begin
      sdo_oe <= 1'b0;
    end else if (state == dsfr_pkg::ST_FRAME && sclk_fall) begin
      txs <= {txs[30:0], 1'b0};
      sdo <= txs[30];
    end
  end

  property p_len_crc;
    crc_enable && frm_end && state == dsfr_pkg::ST_FRAME && cnt != dsfr_pkg::LEN_CRC |=> !frame_valid;
  endproperty
  a_len_crc: assert property (p_len_crc) else $error("Wrong-length frame accepted");
  property p_len_plain;
    !crc_enable && frm_end && state == dsfr_pkg::ST_FRAME && cnt == dsfr_pkg::LEN_PLAIN && slip_ok && dev_ok
      |=> frame_valid;
  endproperty
  a_len_plain: assert property (p_len_plain) else $error("24-bit frame refused");
  property p_dev;
    frm_end && cmd.dev != sy[4:3] |=> !frame_valid;
  endproperty
  a_dev: assert property (p_dev) else $error("Frame for other device accepted");
  property p_rsv;
    frame_valid && last_cmd.adr > dsfr_pkg::ADR_LAST |-> invalid_access;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved access not flagged");
  property p_busy_ign;
    busy && !conv_done |=> !adc_start;
  endproperty
  a_busy_ign: assert property (p_busy_ign) else $error("Conversion started while busy");
  property p_res;
    conv_done |=> res_sel == $past(diag_input_sel) && res == $past(adc_result) && !busy;
  endproperty
  a_res: assert property (p_res) else $error("Result not captured at completion");
  property p_ptr;
    $changed(ptr) && !$past(cfg_cmd) |-> $past(conv_done);
  endproperty
  a_ptr: assert property (p_ptr) else $error("Pointer moved before conversion end");
  property p_stat_busy;
    frm_start && busy && mode == dsfr_pkg::RB_AUTO |=> txs[dsfr_pkg::STAT_BUSY];
  endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("Busy missing from status");
  property p_sync_pat;
    frm_start && mode == dsfr_pkg::RB_TWO_STAGE |=> txs[31:30] == dsfr_pkg::SYNC_PAT ##1 sdo_oe;
  endproperty
  a_sync_pat: assert property (p_sync_pat) else $error("Read frame sync pattern wrong");
  property p_oe_idle;
    sy[1] && sy_d[1] |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("Output driven while deselected");
  property p_shared;
    frm_start && mode == dsfr_pkg::RB_SHARED && !shared_flag |=> !sdo_oe;
  endproperty
  a_shared: assert property (p_shared) else $error("Shared mode drove without flag");
  c_valid:  cover property (frame_valid);
  c_conv:   cover property (conv_done && seq_conv);
  c_echo:   cover property (frm_start && mode == dsfr_pkg::RB_ECHO && echo_ph);
  c_invalid: cover property (invalid_access);
endmodule : dsfr_serial_frame
